// ==== src/pifc_pkg.sv ====
// Package with constants and types shared by the interrupt controller files.
package pifc_pkg;
	localparam int PIFC_N_INT     = 19;
	localparam int PIFC_N_EXT     = 4;
	localparam int PIFC_N_SRC     = 23;
	localparam int PIFC_PRIO_W    = 3;
	localparam int PIFC_N_LEVELS  = 8;
	localparam int PIFC_SYNC_LEN  = 3;
	localparam int PIFC_IDX_W     = 5;
	localparam logic [2:0] PIFC_SYNC_RST_HI = 3'h7;
	localparam logic [2:0] PIFC_SYNC_RST_LO = 3'h0;
	localparam logic [PIFC_PRIO_W-1:0] PIFC_PRIO_NONE = 3'h0;
	localparam logic [PIFC_IDX_W-1:0] PIFC_IDX_NONE = 5'h1F;
	typedef enum logic {PIFC_SENSE_LEVEL, PIFC_SENSE_EDGE} pifc_sense_e;
endpackage

// ==== src/pifc_sync_if.sv ====
// Interface that carries a synchronised pin level and its edge strobes.
`timescale 1ns/1ps
interface pifc_sync_if;
	logic level;
	logic rise;
	logic fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface

// ==== src/pifc_pin_sync.sv ====
// Three-stage pin synchroniser with agreed-level edge detection.
`timescale 1ns/1ps
module pifc_pin_sync
	import pifc_pkg::*;
#(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic   i_clock,
	input  wire logic   i_rst,
	input  wire logic   i_pin,
	pifc_sync_if.src    sync
);
	if (PIFC_SYNC_LEN != 3) begin : g_bad_sync_len
		$error("pifc_pin_sync: the synchroniser is built for three stages");
	end

	logic [2:0] stage_r;
	logic [2:0] stage_nxt;
	logic       level_r;
	logic       level_nxt;
	logic       rise_r;
	logic       rise_nxt;
	logic       fall_r;
	logic       fall_nxt;

	always_comb begin
		stage_nxt = {stage_r[1:0], i_pin};
		level_nxt = level_r;
		if (stage_r[1] == stage_r[2]) begin
			level_nxt = stage_r[2];
		end
		rise_nxt = level_nxt & ~level_r;
		fall_nxt = ~level_nxt & level_r;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			stage_r <= RST_VAL ? PIFC_SYNC_RST_HI : PIFC_SYNC_RST_LO;
			level_r <= RST_VAL;
			rise_r  <= 1'b0;
			fall_r  <= 1'b0;
		end else begin
			stage_r <= stage_nxt;
			level_r <= level_nxt;
			rise_r  <= rise_nxt;
			fall_r  <= fall_nxt;
		end
	end

	assign sync.level = level_r;
	assign sync.rise  = rise_r;
	assign sync.fall  = fall_r;
endmodule // pifc_pin_sync

// ==== src/pifc_ctrl.sv ====
// Prioritised fast and normal interrupt controller top.
`timescale 1ns/1ps
// Function
// R1 - One fast source from the active-low pin is forwarded to the core fast input.
// R2 - Twenty-three normal sources: nineteen internal plus four external pins.
// R3 - Every normal source has its own priority among eight levels; only the normal sources have a priority field, the fast source has none.
// R4 - Level-sensed pins use a software-chosen active level.
// R5 - Edge-sensed pins use a software-chosen rising or falling edge.
// R6 - Fast requests are detected only on a falling pin edge.
// R7 - Only this block drives the core fast and normal request inputs.
// R8 - Highest pending priority wins; ties go to the lowest source index.
module pifc_ctrl
	import pifc_pkg::*;
#(
	parameter int N_INT = PIFC_N_INT,
	parameter int N_EXT = PIFC_N_EXT
) (
	input  wire logic                              i_clock,
	input  wire logic                              i_rst,
	input  wire logic [N_INT-1:0]                  i_int_req,
	input  wire logic [N_EXT-1:0]                  i_ext_irq_pins,
	input  wire logic                              i_ext_fast_irq_pin_n,
	input  wire logic [(N_INT+N_EXT)*PIFC_PRIO_W-1:0] i_src_prio,
	input  wire logic [N_EXT-1:0]                  i_ext_edge_mode,
	input  wire logic [N_EXT-1:0]                  i_ext_polarity_high,
	input  wire logic [N_EXT-1:0]                  i_ext_clear,
	input  wire logic                              i_fast_clear,
	output logic                                   o_core_irq,
	output logic                                   o_core_fiq,
	output logic [PIFC_IDX_W-1:0]                  o_irq_src,
	output logic [PIFC_PRIO_W-1:0]                 o_irq_prio,
	output logic [N_EXT-1:0]                       o_ext_pending
);
	localparam int N_SRC = N_INT + N_EXT;

	// ****************************************
	// Elaboration checks
	// ****************************************
	// The source count must match the packed priority layout.
	if (N_SRC != PIFC_N_SRC) begin : g_bad_src_count
		$error("pifc_ctrl: source count differs from the package");
	end
	// One index code is kept free to mean that no source requests.
	if (N_SRC > 2**PIFC_IDX_W - 1) begin : g_bad_idx_width
		$error("pifc_ctrl: source index does not fit its field");
	end
	if (N_INT < 1 || N_EXT < 1) begin : g_bad_split
		$error("pifc_ctrl: internal and external source counts must be positive");
	end
	if (PIFC_N_LEVELS != 2**PIFC_PRIO_W) begin : g_bad_levels
		$error("pifc_ctrl: priority field must give exactly the level count");
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	pifc_sync_if fast_sync ();
	pifc_sync_if ext_sync [N_EXT] ();

	// The fast pin idles high, so its stages start high and reset never reads as a fall.
	pifc_pin_sync #(.RST_VAL(1'b1)) u_fast_sync (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_pin   (i_ext_fast_irq_pin_n),
		.sync    (fast_sync)
	);

	logic [N_EXT-1:0] ext_level;
	logic [N_EXT-1:0] ext_rise;
	logic [N_EXT-1:0] ext_fall;

	// External pins start low, so a pin already high at release reads as a rising edge.
	for (genvar g = 0; g < N_EXT; g++) begin : g_ext
		pifc_pin_sync #(.RST_VAL(1'b0)) u_sync (
			.i_clock (i_clock),
			.i_rst   (i_rst),
			.i_pin   (i_ext_irq_pins[g]),
			.sync    (ext_sync[g])
		);
		assign ext_level[g] = ext_sync[g].level;
		assign ext_rise[g]  = ext_sync[g].rise;
		assign ext_fall[g]  = ext_sync[g].fall;
	end

	// ****************************************
	// Source conditioning
	// ****************************************
	// Level sense: the pin requests while it sits at the chosen level.
	function automatic logic level_hit(input logic level, input logic pol_high);
		level_hit = ~(level ^ pol_high);
	endfunction

	// Edge sense: only the strobe of the chosen direction registers a request.
	function automatic logic edge_hit(input logic rise, input logic fall, input logic pol_high);
		edge_hit = pol_high ? rise : fall;
	endfunction

	logic [N_EXT-1:0] edge_pend_r;
	logic [N_EXT-1:0] edge_pend_nxt;
	logic [N_EXT-1:0] ext_req;

	always_comb begin
		edge_pend_nxt = edge_pend_r;
		ext_req       = '0;
		for (int i = 0; i < N_EXT; i++) begin
			if (i_ext_edge_mode[i] == PIFC_SENSE_EDGE) begin
				// R5 selected edge
				if (i_ext_clear[i]) begin
					edge_pend_nxt[i] = 1'b0;
				end
				if (edge_hit(ext_rise[i], ext_fall[i], i_ext_polarity_high[i])) begin
					edge_pend_nxt[i] = 1'b1;
				end
				ext_req[i] = edge_pend_r[i];
			end else begin
				// R4 selected level
				edge_pend_nxt[i] = 1'b0;
				ext_req[i]       = level_hit(ext_level[i], i_ext_polarity_high[i]);
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			edge_pend_r <= '0;
		end else begin
			edge_pend_r <= edge_pend_nxt;
		end
	end

	// ****************************************
	// Fast request capture
	// ****************************************
	logic fast_pend_r;
	logic fast_pend_nxt;

	always_comb begin
		fast_pend_nxt = fast_pend_r;
		if (i_fast_clear) begin
			fast_pend_nxt = 1'b0;
		end
		// A fall seen in the clearing cycle wins, so no request is lost.
		// R6 falling edge only
		if (fast_sync.fall) begin
			fast_pend_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			fast_pend_r <= 1'b0;
		end else begin
			fast_pend_r <= fast_pend_nxt;
		end
	end

	// ****************************************
	// Priority arbitration
	// ****************************************
	function automatic logic [PIFC_PRIO_W-1:0] prio_of(input logic [N_SRC*PIFC_PRIO_W-1:0] p, input int idx);
		prio_of = p[idx*PIFC_PRIO_W +: PIFC_PRIO_W];
	endfunction

	logic [N_SRC-1:0]       src_req;
	logic                   win_vld;
	logic [PIFC_IDX_W-1:0]  win_idx;
	logic [PIFC_PRIO_W-1:0] win_prio;
	logic                   irq_r;
	logic                   irq_nxt;
	logic                   fiq_r;
	logic                   fiq_nxt;
	logic [PIFC_IDX_W-1:0]  src_r;
	logic [PIFC_IDX_W-1:0]  src_nxt;
	logic [PIFC_PRIO_W-1:0] prio_r;
	logic [PIFC_PRIO_W-1:0] prio_nxt;

	always_comb begin
		// R2 all normal sources
		src_req  = {ext_req, i_int_req};
		win_vld  = 1'b0;
		win_idx  = PIFC_IDX_NONE;
		win_prio = PIFC_PRIO_NONE;
		// Lower indices are visited first, so a tie keeps the lowest index.
		for (int i = 0; i < N_SRC; i++) begin
			// R3 R8 strict greater keeps lowest index
			if (src_req[i] && (!win_vld || prio_of(i_src_prio, i) > win_prio)) begin
				win_vld  = 1'b1;
				win_idx  = PIFC_IDX_W'(i);
				win_prio = prio_of(i_src_prio, i);
			end
		end
		// R7 single driver of core requests
		irq_nxt  = win_vld;
		src_nxt  = win_idx;
		prio_nxt = win_prio;
		// R1 forward fast request
		fiq_nxt  = fast_pend_r;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			irq_r  <= 1'b0;
			fiq_r  <= 1'b0;
			src_r  <= PIFC_IDX_NONE;
			prio_r <= PIFC_PRIO_NONE;
		end else begin
			irq_r  <= irq_nxt;
			fiq_r  <= fiq_nxt;
			src_r  <= src_nxt;
			prio_r <= prio_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Every core-facing output comes straight from a register.
	assign o_core_irq    = irq_r;
	assign o_core_fiq    = fiq_r;
	assign o_irq_src     = src_r;
	assign o_irq_prio    = prio_r;
	assign o_ext_pending = edge_pend_r;
endmodule // pifc_ctrl

// ==== verification/pifc_core_model.sv ====
// Core model that takes the fast request and clears it.
`timescale 1ns/1ps
module pifc_core_model #(parameter int ACK_DELAY = 3) (
	input  wire logic i_clock,
	input  wire logic i_fiq,
	output logic      o_fast_clear = 1'b0
);
	int wait_r = 0;
	always @(posedge i_clock) begin
		wait_r <= i_fiq ? wait_r + 1 : 0;
		o_fast_clear <= i_fiq && wait_r >= ACK_DELAY;
	end
endmodule // pifc_core_model

// ==== verification/pifc_ctrl_properties.sv ====
// Checker for the interrupt controller ports.
`timescale 1ns/1ps
module pifc_ctrl_properties
	import pifc_pkg::*;
#(parameter int N_INT = 19, parameter int N_EXT = 4) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [N_INT-1:0] i_int_req,
	input wire logic i_ext_fast_irq_pin_n,
	input wire logic [(N_INT+N_EXT)*PIFC_PRIO_W-1:0] i_src_prio,
	input wire logic [N_EXT-1:0] i_ext_edge_mode,
	input wire logic [N_EXT-1:0] i_ext_clear,
	input wire logic i_fast_clear,
	input wire logic o_core_irq,
	input wire logic o_core_fiq,
	input wire logic [PIFC_IDX_W-1:0] o_irq_src,
	input wire logic [PIFC_PRIO_W-1:0] o_irq_prio,
	input wire logic [N_EXT-1:0] o_ext_pending
);
	wire logic [2:0] prio_w = 3'(i_src_prio >> (32'(o_irq_src) * 3));
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	sequence s_quiet;
		(i_ext_fast_irq_pin_n && !o_core_fiq)[*8];
	endsequence
	a_reset_clears: assert property (disable iff (1'b0) i_rst |=> !o_core_irq && !o_core_fiq &&
		o_irq_src == PIFC_IDX_NONE && o_irq_prio == PIFC_PRIO_NONE && o_ext_pending == '0) else $error("reset");
	a_int_req_irq: assert property (i_int_req != '0 |=> o_core_irq) else $error("irq");
	a_idle_none: assert property (!o_core_irq |-> o_irq_src == PIFC_IDX_NONE) else $error("idle");
	a_src_range: assert property (o_core_irq |-> o_irq_src < 5'(N_INT + N_EXT)) else $error("range");
	a_prio_win: assert property (o_core_irq && $stable(i_src_prio) |-> o_irq_prio == prio_w) else $error("prio");
	a_fiq_hold: assert property (o_core_fiq && !$past(i_fast_clear) |=> o_core_fiq) else $error("fiq");
	a_fast_quiet: assert property (s_quiet |=> !o_core_fiq) else $error("quiet");
	a_level_zero: assert property ((o_ext_pending & ~$past(i_ext_edge_mode)) == '0) else $error("lvl");
	a_pend_hold: assert property (o_ext_pending != '0 |=>
		($past(o_ext_pending & ~i_ext_clear & i_ext_edge_mode) & ~o_ext_pending) == '0) else $error("pend");
endmodule // pifc_ctrl_properties
bind pifc_ctrl pifc_ctrl_properties #(.N_INT(N_INT), .N_EXT(N_EXT)) u_props (
	.i_clock              (i_clock),
	.i_rst                (i_rst),
	.i_int_req            (i_int_req),
	.i_ext_fast_irq_pin_n (i_ext_fast_irq_pin_n),
	.i_src_prio           (i_src_prio),
	.i_ext_edge_mode      (i_ext_edge_mode),
	.i_ext_clear          (i_ext_clear),
	.i_fast_clear         (i_fast_clear),
	.o_core_irq           (o_core_irq),
	.o_core_fiq           (o_core_fiq),
	.o_irq_src            (o_irq_src),
	.o_irq_prio           (o_irq_prio),
	.o_ext_pending        (o_ext_pending)
);

// ==== verification/pifc_ctrl_tb.sv ====
// Self-checking bench for the interrupt controller.
`timescale 1ns/1ps
module pifc_ctrl_tb;
	logic clk = 0, rst = 1, fn = 1, irq, fiq, fclr;
	logic [18:0] req = 0;
	logic [3:0] pins = 0, mode = 0, pol = 4'hF, clr = 0, pend;
	logic [68:0] prio = 0;
	logic [4:0] src;
	logic [2:0] pr;
	logic [7:0] q[$], last = 8'h1F, seen = 8'h1F;
	int failures = 0, check_count = 0;
	pifc_ctrl u_pifc_ctrl (.i_clock(clk), .i_rst(rst), .i_int_req(req), .i_ext_irq_pins(pins),
		.i_ext_fast_irq_pin_n(fn), .i_src_prio(prio), .i_ext_edge_mode(mode), .i_ext_polarity_high(pol),
		.i_ext_clear(clr), .i_fast_clear(fclr), .o_core_irq(irq), .o_core_fiq(fiq), .o_irq_src(src),
		.o_irq_prio(pr), .o_ext_pending(pend));
	pifc_core_model u_pifc_core_model (.i_clock(clk), .i_fiq(fiq), .o_fast_clear(fclr));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	function automatic logic [7:0] win(input logic [22:0] a, input logic [68:0] p);
		logic [7:0] w = 8'h1F;
		for (int k = 0; k < 23; k++) begin
			if (a[k] && (w == 8'h1F || p[3*k+:3] > w[7:5])) w = {p[3*k+:3], 5'(k)};
		end
		return w;
	endfunction
	task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic drive(input logic [18:0] r, input logic [68:0] p, input logic [3:0] g, o, m, c, ea);
		req <= r;
		prio <= p;
		pins <= g;
		pol <= o;
		mode <= m;
		clr <= c;
		if (win({ea, r}, p) !== last) q.push_back(win({ea, r}, p));
		last = win({ea, r}, p);
		repeat (8) @(posedge clk);
	endtask
	task automatic final_report();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial forever #5 clk = ~clk;
	initial begin
		#50000;
		failures++;
		final_report();
	end
	always @(posedge clk) begin
		#1;
		if (!rst && {pr, src} !== seen) begin
			seen = {pr, src};
			check("winner", seen, q.size() ? q.pop_front() : 8'hFF);
		end
	end
	initial begin
		logic [31:0] sd = 15;
		logic [18:0] r = 0;
		logic [68:0] p = 0;
		logic [3:0] g = 0, o = 4'hF;
		repeat (16) @(posedge clk);
		rst <= 0;
		for (int i = 0; i < 60; i++) begin
			sd = xs(sd);
			if (sd[0]) begin
				r = sd[31:13];
				p = {sd, xs(sd), sd[4:0]};
				o = sd[12:9];
			end else g = sd[8:5];
			drive(r, p, g, o, 4'h0, 4'h0, ~(g ^ o));
		end
		$display("level test done");
		drive(0, p, g, 4'hA, 4'h0, 4'h0, ~(g ^ 4'hA));
		drive(0, p, 4'h5, 4'hA, 4'h0, 4'h0, 4'h0);
		drive(0, p, 4'h5, 4'hA, 4'hF, 4'h0, 4'h0);
		drive(0, p, 4'hF, 4'hA, 4'hF, 4'h0, 4'hA);
		check("pend", pend, 4'hA);
		drive(0, p, 4'h0, 4'hA, 4'hF, 4'h0, 4'hF);
		check("pend", pend, 4'hF);
		drive(0, p, 4'h0, 4'hA, 4'hF, 4'hF, 4'h0);
		check("pend", pend, 4'h0);
		drive(0, p, 4'h0, 4'h0, 4'h0, 4'h0, 4'hF);
		$display("edge test done");
		fn <= 0;
		for (int n = 0; n < 12 && fiq !== 1'b1; n++) @(posedge clk);
		check("fiq", fiq, 1);
		repeat (10) @(posedge clk);
		check("fiq", fiq, 0);
		fn <= 1;
		repeat (12) @(posedge clk);
		check("fiq", fiq, 0);
		check("queue", 8'(q.size()), 8'h00);
		$display("fast test done");
		final_report();
	end
endmodule // pifc_ctrl_tb
